// ===== inc/swlk_pkg.sv
// Purpose: Shared constants of the address and VLAN lookup block
// Assumes: 16-bit register port, word addressed
// Notes:   Control word holds read flag, table select and entry index
package swlk_pkg;
	localparam logic [2:0] OFS_CTRL   = 3'h0;
	localparam logic [2:0] OFS_TOP    = 3'h1;
	localparam logic [2:0] OFS_TWO    = 3'h2;
	localparam logic [2:0] OFS_THREE  = 3'h3;
	localparam logic [2:0] OFS_LOW    = 3'h4;
	localparam logic [2:0] OFS_FIVE   = 3'h5;
	localparam logic [2:0] OFS_GCTL2  = 3'h6;
	localparam logic [2:0] OFS_PVID   = 3'h7;
	localparam int CTL_READ_BIT  = 12;
	localparam int CTL_SEL_HI    = 11;
	localparam int CTL_SEL_LO    = 10;
	localparam int VLAN_MODE_BIT = 15;
	localparam logic [1:0] SEL_STATIC  = 2'h0;
	localparam logic [1:0] SEL_VLAN    = 2'h1;
	localparam logic [1:0] SEL_LEARNED = 2'h2;
	localparam int STAT_ENTRIES = 8;
	localparam int VLAN_ENTRIES = 16;
	localparam int LRN_ENTRIES  = 1024;
	localparam logic [2:0]  VLAN_MEMB_RST = 3'h7;
	localparam logic [11:0] VLAN_VID_RST  = 12'h001;
	localparam logic [11:0] NULL_VID      = 12'h000;
	localparam logic [2:0]  ALL_PORTS     = 3'h7;
	localparam int AGE_TICKS = 100000;
	typedef enum logic [1:0] {
		SWLK_IDLE  = 2'b00,
		SWLK_FETCH = 2'b01,
		SWLK_LOAD  = 2'b11
	} swlk_state_t;
endpackage

// ===== src/swlk_lookup.sv
// Purpose: Indirect table access and ingress VLAN/address lookup
// Assumes: One clock, synchronous active-high reset, clock enable
// Notes:   Learned table is direct mapped by a fold of filter id and address
`timescale 1ns/10ps
module swlk_lookup
	import swlk_pkg::*;
#(
	parameter int AGE_CYCLES = AGE_TICKS
) (
	input  wire logic        clock_i,      // 100 MHz clock
	input  wire logic        rst_i,        // Synchronous reset
	input  wire logic        ce_i,         // Clock enable
	input  wire logic [2:0]  addr_i,       // Register index
	input  wire logic [15:0] wdata_i,      // Write data
	input  wire logic        wr_i,         // Write strobe
	input  wire logic        rd_i,         // Read strobe
	output logic      [15:0] rdata_o,      // Read data, cycle after strobe
	input  wire logic        frm_valid_i,  // Ingress frame header valid
	input  wire logic [1:0]  frm_port_i,   // Ingress port 0..2
	input  wire logic        frm_tagged_i, // Frame carries a VLAN tag
	input  wire logic [11:0] frm_vid_i,    // Tag VLAN identifier
	input  wire logic [47:0] frm_da_i,     // Destination address
	input  wire logic [47:0] frm_sa_i,     // Source address
	output logic             fwd_valid_o,  // Decision pulse
	output logic             fwd_drop_o,   // Frame discarded
	output logic      [2:0]  fwd_ports_o   // Egress port mask
);
	// Control and staging registers
	logic [15:0] indirect_access_control;
	logic [7:0]  indirect_data_word_top;
	logic [15:0] indirect_data_word_two;
	logic [15:0] indirect_data_word_three;
	logic [15:0] indirect_data_word_low;
	logic [15:0] indirect_data_word_five;
	logic [15:0] global_control_two;
	logic [11:0] port_default_vid [3];
	logic        not_ready;
	swlk_state_t state;

	// Tables
	logic [57:0] stat_tab [STAT_ENTRIES];
	logic [19:0] vlan_tab [VLAN_ENTRIES];
	logic [55:0] lrn_mem  [LRN_ENTRIES];
	logic [LRN_ENTRIES-1:0] lrn_vld;
	logic [10:0] lrn_count;
	localparam int AGE_W = $clog2(AGE_CYCLES);
	logic [1:0]  age_epoch;
	logic [AGE_W-1:0] age_cnt;

	// Register decode
	wire we_ctrl  = ce_i && wr_i && addr_i == OFS_CTRL;
	wire we_top   = ce_i && wr_i && addr_i == OFS_TOP;
	wire we_two   = ce_i && wr_i && addr_i == OFS_TWO;
	wire we_three = ce_i && wr_i && addr_i == OFS_THREE;
	wire we_low   = ce_i && wr_i && addr_i == OFS_LOW;
	wire we_five  = ce_i && wr_i && addr_i == OFS_FIVE;
	wire we_gctl  = ce_i && wr_i && addr_i == OFS_GCTL2;
	wire we_pvid  = ce_i && wr_i && addr_i == OFS_PVID;
	wire load_now = ce_i && state == SWLK_LOAD;
	wire        cmd_read = wdata_i[CTL_READ_BIT];
	wire [1:0]  cmd_sel  = wdata_i[CTL_SEL_HI:CTL_SEL_LO];
	wire [1:0]  op_sel   = indirect_access_control[CTL_SEL_HI:CTL_SEL_LO];
	wire [9:0]  op_idx   = indirect_access_control[9:0];
	wire [71:0] staged   = {indirect_data_word_top, indirect_data_word_three,
		indirect_data_word_two, indirect_data_word_five, indirect_data_word_low};
	wire        stat_wr  = we_ctrl && !cmd_read && cmd_sel == SEL_STATIC;
	wire        vlan_wr  = we_ctrl && !cmd_read && cmd_sel == SEL_VLAN;
	// Empty and a single entry both show a zero count field
	wire        lrn_empty = lrn_count == 11'h000;
	wire [9:0]  lrn_field = lrn_empty ? 10'h000 : 10'(lrn_count - 11'h001);

	// Readout image of the addressed entry; unlearned slots read as zero
	wire [55:0] lrn_rd = lrn_vld[op_idx] ? lrn_mem[op_idx] : 56'h0;
	// Status bits and valid count less one ride above every learned readout
	wire [15:0] lrn_status = {1'b0, 4'h0, lrn_empty, lrn_field};
	wire [71:0] rd_image =
		(op_sel == SEL_LEARNED) ? {lrn_status, lrn_rd} :
		(op_sel == SEL_VLAN)    ? {52'h0, vlan_tab[op_idx[3:0]]} :
		                          {14'h0, stat_tab[op_idx[2:0]]};

	// Ingress VLAN assignment
	wire        vlan_mode = global_control_two[VLAN_MODE_BIT];
	wire [11:0] in_vid = (!frm_tagged_i || frm_vid_i == NULL_VID) ?
		port_default_vid[frm_port_i] : frm_vid_i;
	logic [VLAN_ENTRIES-1:0] vhit;
	logic [2:0]  v_memb;
	logic [3:0]  v_fid;
	logic        v_ok;
	logic [STAT_ENTRIES-1:0] shit;
	logic [2:0]  s_ports;
	logic        s_any;
	// Filter id: the VLAN entry's in VLAN mode, otherwise zero
	wire  [3:0]  filter_group_id = vlan_mode ? v_fid : 4'h0;

	genvar g;
	generate
		for (g = 0; g < VLAN_ENTRIES; g++) begin : g_vlan
			wire [11:0] vlan_identifier = vlan_tab[g][11:0];
			assign vhit[g] = vlan_identifier == in_vid;
		end
		for (g = 0; g < STAT_ENTRIES; g++) begin : g_stat
			wire [57:0] ent  = stat_tab[g];
			// Override turns an entry on even when it is not valid
			wire        en   = ent[51] || ent[52];
			wire        fidm = !ent[53] || ent[57:54] == filter_group_id;
			assign shit[g] = en && fidm && ent[47:0] == frm_da_i;
		end
	endgenerate

	always_comb begin
		v_memb = 3'h0;
		v_fid  = 4'h0;
		v_ok   = 1'b0;
		for (int i = VLAN_ENTRIES - 1; i >= 0; i--) begin
			if (vhit[i]) begin
				v_memb = vlan_tab[i][18:16];
				v_fid  = vlan_tab[i][15:12];
				v_ok   = vlan_tab[i][19];
			end
		end
	end

	wire [2:0]  members = vlan_mode ? v_memb : ALL_PORTS;
	// A VLAN_IDENTIFIER with no matching entry is treated as invalid
	wire        drop    = vlan_mode && !v_ok;
	// The ingress port never receives its own frame back
	wire [2:0]  in_mask = 3'(3'h1 << frm_port_i);

	always_comb begin
		s_ports = 3'h0;
		s_any   = 1'b0;
		for (int i = STAT_ENTRIES - 1; i >= 0; i--) begin
			if (shit[i]) begin
				s_ports = stat_tab[i][50:48];
				s_any   = 1'b1;
			end
		end
	end

	// Learned table is indexed by a fold of filter id and address
	function automatic logic [9:0] fold(input logic [3:0] f, input logic [47:0] m);
		fold = m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]} ^ {6'h0, f};
	endfunction
	wire [9:0]  da_idx = fold(filter_group_id, frm_da_i);
	wire [9:0]  sa_idx = fold(filter_group_id, frm_sa_i);
	wire [55:0] da_ent = lrn_mem[da_idx];
	wire [55:0] sa_ent = lrn_mem[sa_idx];
	wire        d_hit  = lrn_vld[da_idx] && da_ent[51:0] == {filter_group_id, frm_da_i};
	wire        sa_hit = lrn_vld[sa_idx] && sa_ent[51:0] == {filter_group_id, frm_sa_i};
	wire [2:0]  d_ports = 3'(3'h1 << da_ent[53:52]);
	wire [2:0]  dest = s_any ? s_ports : (d_hit ? d_ports : members);
	wire [2:0]  next_ports = drop ? 3'h0 : (dest & ~in_mask);
	wire        learn = ce_i && frm_valid_i && !drop && !sa_hit;
	wire        age_tick = age_cnt == ($clog2(AGE_CYCLES))'(AGE_CYCLES - 1);

	// Register writes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			indirect_access_control  <= 16'h0000;
			indirect_data_word_two   <= 16'h0000;
			indirect_data_word_three <= 16'h0000;
			indirect_data_word_low   <= 16'h0000;
			indirect_data_word_five  <= 16'h0000;
			global_control_two       <= 16'h0000;
			for (int i = 0; i < 3; i++) port_default_vid[i] <= VLAN_VID_RST;
		end else begin
			if (we_ctrl) indirect_access_control <= wdata_i;
			if (we_pvid) port_default_vid[wdata_i[13:12]] <= wdata_i[11:0];
			if (we_gctl) global_control_two <= wdata_i;
			// The entry latch wins over a software word write in that cycle
			if (load_now) begin
				indirect_data_word_three <= rd_image[63:48];
				indirect_data_word_two   <= rd_image[47:32];
				indirect_data_word_five  <= rd_image[31:16];
				indirect_data_word_low   <= rd_image[15:0];
			end else begin
				if (we_two)   indirect_data_word_two   <= wdata_i;
				if (we_three) indirect_data_word_three <= wdata_i;
				if (we_five)  indirect_data_word_five  <= wdata_i;
				if (we_low)   indirect_data_word_low   <= wdata_i;
			end
		end
	end

	// Indirect read sequencer
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state                  <= SWLK_IDLE;
			not_ready              <= 1'b0;
			indirect_data_word_top <= 8'h00;
		end else if (ce_i) begin
			case (state)
				SWLK_IDLE: begin
					if (we_ctrl && cmd_read) begin
						state     <= SWLK_FETCH;
						not_ready <= 1'b1;
					end else if (we_top) begin
						indirect_data_word_top <= wdata_i[7:0];
					end
				end
				// One cycle for the table read to settle
				SWLK_FETCH: state <= SWLK_LOAD;
				SWLK_LOAD: begin
					state                  <= SWLK_IDLE;
					indirect_data_word_top <= rd_image[71:64];
					not_ready              <= 1'b0;
				end
				default: state <= SWLK_IDLE;
			endcase
		end
	end

	// Static and VLAN tables, software writes only
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int i = 0; i < STAT_ENTRIES; i++) stat_tab[i] <= 58'h0;
			for (int i = 0; i < VLAN_ENTRIES; i++)
				vlan_tab[i] <= {1'b1, VLAN_MEMB_RST, 4'h0, VLAN_VID_RST};
		end else begin
			if (stat_wr) stat_tab[wdata_i[2:0]] <= staged[57:0];
			if (vlan_wr) vlan_tab[wdata_i[3:0]] <= staged[19:0];
		end
	end

	// Learned table: filled only by the lookup path, never by software
	// New entry: timestamp, source port code, filter id, address
	wire [55:0] lrn_new = {age_epoch, frm_port_i, filter_group_id, frm_sa_i};
	// A colliding slot is overwritten and the count is left alone
	always_ff @(posedge clock_i) begin
		if (learn) lrn_mem[sa_idx] <= lrn_new;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lrn_vld   <= '0;
			lrn_count <= 11'h000;
			age_cnt   <= '0;
			age_epoch <= 2'h0;
		end else if (ce_i) begin
			age_cnt <= age_tick ? '0 : age_cnt + AGE_W'(1);
			if (age_tick) age_epoch <= age_epoch + 2'h1;
			if (learn) begin
				lrn_vld[sa_idx] <= 1'b1;
				// Count never falls: entries are not evicted
				if (!lrn_vld[sa_idx]) lrn_count <= lrn_count + 11'h001;
			end
		end
	end

	// Read port and decision outputs
	wire [15:0] rd_mux =
		(addr_i == OFS_CTRL)  ? indirect_access_control :
		(addr_i == OFS_TOP)   ? {8'h00, not_ready, indirect_data_word_top[6:0]} :
		(addr_i == OFS_TWO)   ? indirect_data_word_two :
		(addr_i == OFS_THREE) ? indirect_data_word_three :
		(addr_i == OFS_LOW)   ? indirect_data_word_low :
		(addr_i == OFS_FIVE)  ? indirect_data_word_five :
		(addr_i == OFS_GCTL2) ? global_control_two : 16'h0000;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o     <= 16'h0000;
			fwd_valid_o <= 1'b0;
			fwd_drop_o  <= 1'b0;
			fwd_ports_o <= 3'h0;
		end else if (ce_i) begin
			rdata_o     <= rd_i ? rd_mux : 16'h0000;
			// Valid pulses; drop and ports hold between frames
			fwd_valid_o <= frm_valid_i;
			if (frm_valid_i) begin
				fwd_drop_o  <= drop;
				fwd_ports_o <= next_ports;
			end
		end
	end
endmodule // swlk_lookup

// ===== test/swlk_lookup_sva.sv
// Purpose: Port-level checker for the lookup block
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
module swlk_lookup_chk
	import swlk_pkg::*;
#(
	parameter int AGE_CYCLES = AGE_TICKS
) (
	input wire logic        clock_i,     // Clock
	input wire logic        rst_i,       // Reset
	input wire logic        ce_i,        // Enable
	input wire logic [2:0]  addr_i,      // Index
	input wire logic [15:0] wdata_i,     // Write data
	input wire logic        wr_i,        // Write strobe
	input wire logic        rd_i,        // Read strobe
	input wire logic [15:0] rdata_o,     // Read data
	input wire logic        frm_valid_i, // Frame in
	input wire logic        fwd_valid_o, // Decision
	input wire logic        fwd_drop_o,  // Drop
	input wire logic [2:0]  fwd_ports_o  // Ports
);
	logic vmode;
	logic lrn_sel;
	logic seen;
	wire  ctl_rd = ce_i && wr_i && addr_i == OFS_CTRL && wdata_i[CTL_READ_BIT];
	wire  top_rd = ce_i && rd_i && addr_i == OFS_TOP;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Seen means a learn may have happened
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vmode   <= 1'b0;
			lrn_sel <= 1'b0;
			seen    <= 1'b0;
		end else begin
			if (ce_i && wr_i && addr_i == OFS_GCTL2)
				vmode <= wdata_i[VLAN_MODE_BIT];
			if (ce_i && wr_i && addr_i == OFS_CTRL)
				lrn_sel <= wdata_i[CTL_READ_BIT] && wdata_i[11:10] == SEL_LEARNED;
			seen <= seen || (ce_i && frm_valid_i);
		end
	end
	chk_rd_idle: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
		else $error("read data not zero when idle");
	chk_fwd_pulse: assert property (ce_i && frm_valid_i |=> fwd_valid_o)
		else $error("no decision after frame");
	chk_fwd_quiet: assert property (ce_i && !frm_valid_i |=> !fwd_valid_o)
		else $error("decision without frame");
	chk_fwd_hold: assert property (ce_i && !frm_valid_i |=>
		$stable(fwd_ports_o) && $stable(fwd_drop_o))
		else $error("decision changed without frame");
	chk_mode_off: assert property (ce_i && frm_valid_i && !vmode |=> !fwd_drop_o)
		else $error("drop with vlan mode off");
	chk_busy_flag: assert property (ctl_rd ##1 top_rd |=> rdata_o[7])
		else $error("not ready flag missing");
	chk_ready_flag: assert property (ctl_rd ##1 ce_i[*2] ##1 top_rd |=> !rdata_o[7])
		else $error("not ready flag stuck");
	chk_empty_read: assert property (top_rd && lrn_sel && !seen |=>
		rdata_o[7] || rdata_o[2:0] == 3'h4)
		else $error("empty table misreported");
	cov_drop: cover property (fwd_valid_o && fwd_drop_o);
	cov_flood: cover property (fwd_valid_o && fwd_ports_o == 3'h5);
	cov_ready: cover property (ctl_rd ##[1:8] (top_rd ##1 !rdata_o[7]));
endmodule // swlk_lookup_chk

bind swlk_lookup swlk_lookup_chk #(.AGE_CYCLES(AGE_CYCLES)) u_chk (
	.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frm_valid_i(frm_valid_i),
	.fwd_valid_o(fwd_valid_o), .fwd_drop_o(fwd_drop_o), .fwd_ports_o(fwd_ports_o)
);

// ===== test/test_swlk_lookup.sv
// Purpose: Self-checking bench for the lookup block
// Assumes: Clock enable high except one frozen register write
// Notes:   Learned entries are located by a full index scan
`timescale 1ns/10ps
module test_swlk_lookup;
	import swlk_pkg::*;
	localparam logic [47:0] MAC_A = 48'h0A00_0000_0011;
	localparam logic [47:0] MAC_B = 48'h0B00_0000_0022;
	localparam logic [47:0] MAC_C = 48'h0C00_0000_0033;
	localparam logic [47:0] MAC_D = 48'h0D00_0000_0044;
	localparam logic [47:0] MAC_E = 48'h0E00_0000_0055;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        frm_valid_i = 1'b0;
	logic        frm_tagged_i = 1'b0;
	logic [1:0]  frm_port_i = 2'h0;
	logic [2:0]  addr_i = 3'h0;
	logic [11:0] frm_vid_i = 12'h000;
	logic [15:0] wdata_i = 16'h0000;
	logic [47:0] frm_da_i = 48'h0, frm_sa_i = 48'h0;
	logic        fwd_valid_o, fwd_drop_o;
	logic [2:0]  fwd_ports_o;
	logic [15:0] rdata_o, first, top;
	logic [63:0] e;
	int          hits = 0;
	int          num_errors = 0;
	int          checks = 0;
	always #5 clock_i = ~clock_i;
	swlk_lookup #(.AGE_CYCLES(8)) uut (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.frm_valid_i(frm_valid_i), .frm_port_i(frm_port_i), .frm_tagged_i(frm_tagged_i),
		.frm_vid_i(frm_vid_i), .frm_da_i(frm_da_i), .frm_sa_i(frm_sa_i),
		.fwd_valid_o(fwd_valid_o), .fwd_drop_o(fwd_drop_o), .fwd_ports_o(fwd_ports_o)
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask
	// Read command, poll until ready, then the four words in order
	task automatic ent(input logic [15:0] c);
		wr(OFS_CTRL, c);
		rd(OFS_TOP, first);
		top = first;
		for (int i = 0; i < 8 && top[7] !== 1'b0; i++)
			rd(OFS_TOP, top);
		chk({15'h0000, top[7]}, 16'h0000);
		rd(OFS_THREE, e[63:48]);
		rd(OFS_TWO, e[47:32]);
		rd(OFS_FIVE, e[31:16]);
		rd(OFS_LOW, e[15:0]);
	endtask
	// Expected value is {drop, ports}; ports are ignored on a drop
	task automatic frm(input logic [1:0] p, input logic t, input logic [11:0] v,
		input logic [47:0] da, input logic [47:0] sa, input logic [3:0] exp);
		frm_port_i <= p;
		frm_tagged_i <= t;
		frm_vid_i <= v;
		frm_da_i <= da;
		frm_sa_i <= sa;
		frm_valid_i <= 1'b1;
		@(posedge clock_i);
		frm_valid_i <= 1'b0;
		#1;
		chk({11'h000, fwd_valid_o, fwd_drop_o, exp[3] ? exp[2:0] : fwd_ports_o},
			{12'h001, exp});
	endtask
	task automatic finish_test;
		$display("num_errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		#1;
		ent(16'h1800);
		chk({15'h0000, first[7]}, 16'h0001);
		chk(top, 16'h0004);
		chk(e[63:48] | e[47:32] | e[31:16] | e[15:0], 16'h0000);
		ent(16'h1402);
		chk(e[31:16], 16'h000F);
		chk(e[15:0], 16'h0001);
		wr(OFS_FIVE, 16'h000D);
		wr(OFS_LOW, 16'h1005);
		wr(OFS_CTRL, 16'h0400);
		wr(OFS_FIVE, 16'h0007);
		wr(OFS_LOW, 16'h0007);
		wr(OFS_CTRL, 16'h0401);
		frm(2'h2, 1'b1, 12'h007, MAC_C, MAC_A, 4'h3);
		ent(16'h1800);
		chk(top, 16'h0000);
		frm(2'h0, 1'b0, 12'h000, MAC_A, MAC_B, 4'h4);
		wr(OFS_LOW, MAC_A[15:0]);
		wr(OFS_FIVE, MAC_A[31:16]);
		wr(OFS_TWO, MAC_A[47:32]);
		wr(OFS_THREE, 16'h0009);
		wr(OFS_CTRL, 16'h0800);
		wr(OFS_CTRL, 16'h0007);
		ent(16'h1800);
		chk(top, 16'h0000);
		chk({8'h00, e[63:56]}, 16'h0001);
		for (int i = 0; i < LRN_ENTRIES; i++) begin
			ent(16'h1800 | 16'(i));
			if (e[47:0] === MAC_A) begin
				hits++;
				chk({10'h000, e[53:48]}, 16'h0020);
			end
		end
		chk(16'(hits), 16'h0001);
		frm(2'h1, 1'b0, 12'h000, MAC_A, MAC_B, 4'h1);
		wr(OFS_GCTL2, 16'h8000);
		frm(2'h0, 1'b1, 12'h005, MAC_C, MAC_D, 4'h4);
		frm(2'h0, 1'b1, 12'h007, MAC_C, MAC_E, 4'h8);
		ce_i <= 1'b0;
		wr(OFS_GCTL2, 16'h0000);
		ce_i <= 1'b1;
		wr(OFS_PVID, 16'h1007);
		frm(2'h1, 1'b0, 12'h000, MAC_C, MAC_E, 4'h8);
		frm(2'h1, 1'b1, 12'h000, MAC_C, MAC_E, 4'h8);
		frm(2'h1, 1'b1, 12'h005, MAC_C, MAC_D, 4'h5);
		ent(16'h1800);
		chk(top, 16'h0000);
		chk({8'h00, e[63:56]}, 16'h0002);
		finish_test();
	end
endmodule // test_swlk_lookup
